// file: fpl_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------
// Function pin location select: shared constants and types
// ----------------------------------------------------------------------
package fpl_pkg;

  localparam int FPL_DATA_W = 32;
  localparam int FPL_NUM_SEL = 7;
  localparam int FPL_NUM_PIN = 12;
  localparam int FPL_SEL_W = 2;
  localparam int FPL_FIELD_LSB = 0;
  localparam int FPL_FIELD_MSB = 1;
  localparam int FPL_SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Register indices into the selector bank
  // ----------------------------------------------------------------------
  localparam int FPL_IX_SPI1_SELECT = 0;
  localparam int FPL_IX_SPI0_CLOCK = 1;
  localparam int FPL_IX_SET_READY = 2;
  localparam int FPL_IX_CARRIER_DETECT = 3;
  localparam int FPL_IX_BELL_INPUT = 4;
  localparam int FPL_IX_TIMER16_CAPTURE = 5;
  localparam int FPL_IX_SPI1_CLOCK = 6;

  // Byte addresses, ordered as the indices above
  localparam logic [31:0] FPL_ADR_TABLE [FPL_NUM_SEL] = '{
    32'h4004_4018, 32'h4004_40b0, 32'h4004_40b4, 32'h4004_40b8,
    32'h4004_40bc, 32'h4004_40c0, 32'h4004_40c4};
  localparam logic [31:0] FPL_ADR_INPUT_STATUS = 32'h4004_40e0;

  localparam logic [1:0] FPL_SEL_RESET = 2'h0;
  localparam logic [1:0] FPL_CODE_0 = 2'h0;
  localparam logic [1:0] FPL_CODE_1 = 2'h1;
  localparam logic [1:0] FPL_CODE_2 = 2'h2;

  // ----------------------------------------------------------------------
  // Pin indices on the pin vectors
  // ----------------------------------------------------------------------
  localparam int FPL_PIN_PORT0_BIT10 = 0;
  localparam int FPL_PIN_PORT2_BIT11 = 1;
  localparam int FPL_PIN_PORT0_BIT6 = 2;
  localparam int FPL_PIN_PORT2_BIT1 = 3;
  localparam int FPL_PIN_PORT3_BIT1 = 4;
  localparam int FPL_PIN_PORT2_BIT2 = 5;
  localparam int FPL_PIN_PORT3_BIT2 = 6;
  localparam int FPL_PIN_PORT2_BIT3 = 7;
  localparam int FPL_PIN_PORT3_BIT3 = 8;
  localparam int FPL_PIN_PORT2_BIT0 = 9;
  localparam int FPL_PIN_PORT2_BIT4 = 10;
  localparam int FPL_PIN_PORT0_BIT2 = 11;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } fpl_wb_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } fpl_drive_t;

  typedef struct packed {
    logic spi0_serial_clock;
    logic spi1_serial_clock;
    logic spi1_slave_select;
    logic uart_set_ready;
    logic uart_carrier_detect;
    logic uart_phone_bell_input;
    logic timer16_0_capture0_input;
  } fpl_func_in_t;

endpackage : fpl_pkg
`default_nettype wire

// file: fpl_function_pin_location_select.sv
// Functional notes
// RQ1 - The spi0 clock selector sits in bits 1:0 and resets to 00.
// RQ2 - Spi0 clock code 0 uses port0 bit10, code 1 port2 bit11, code 2 port0 bit6.
// RQ3 - The set-ready selector sits in bits 1:0 and resets to 00.
// RQ4 - Set-ready code 0 reads port2 bit1 and code 1 reads port3 bit1.
// RQ5 - The carrier-detect selector sits in bits 1:0 and resets to 00.
// RQ6 - Carrier-detect code 0 reads port2 bit2 and code 1 reads port3 bit2.
// RQ7 - The bell-input selector sits in bits 1:0 and resets to 00.
// RQ8 - Bell-input code 0 reads port2 bit3 and code 1 reads port3 bit3.
// RQ9 - The spi1 slave-select selector sits in bits 1:0 and resets to 00.
// RQ10 - Spi1 slave select code 0 uses port2 bit0 and code 1 port2 bit4.
// RQ11 - The timer capture selector sits in bits 1:0 and resets to 00.
// RQ12 - Timer capture code 0 reads port0 bit2 and code 1 reads port3 bit3.
// RQ13 - The spi1 clock selector sits in bits 1:0 and resets to 00.
// RQ14 - Spi1 clock code 0 uses port2 bit1 and code 1 port3 bit2.
// RQ15 - Software must not write reserved codes; the function is then left unrouted.
// RQ16 - Bits 31:2 of each selector read as zero and ignore writes.
// RQ17 - Only the selected pin serves a function, and a new code acts at the write edge.
`timescale 1ns/1ns
`default_nettype none
module fpl_function_pin_location_select
  import fpl_pkg::*;
#(
  parameter int SYNC_STAGES = FPL_SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fpl_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [FPL_NUM_PIN-1:0] pin_in,
  output logic [FPL_NUM_PIN-1:0] pin_out,
  output logic [FPL_NUM_PIN-1:0] pin_oe,
  input wire fpl_drive_t spi0_serial_clock,
  input wire fpl_drive_t spi1_serial_clock,
  input wire fpl_drive_t spi1_slave_select,
  output fpl_func_in_t func_in
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  logic [FPL_NUM_PIN-1:0] sync_r [SYNC_STAGES];
  logic [FPL_NUM_PIN-1:0] sync_nxt [SYNC_STAGES];
  logic [FPL_NUM_PIN-1:0] pin_s;
  logic [FPL_SEL_W-1:0] sel_r [FPL_NUM_SEL];
  logic [FPL_SEL_W-1:0] sel_nxt [FPL_NUM_SEL];
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic req;
  logic wr_go;
  logic [31:0] rd_val;
  logic [FPL_NUM_PIN-1:0] pout_r;
  logic [FPL_NUM_PIN-1:0] pout_nxt;
  logic [FPL_NUM_PIN-1:0] poe_r;
  logic [FPL_NUM_PIN-1:0] poe_nxt;
  fpl_func_in_t fin_r;
  fpl_func_in_t fin_nxt;

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign func_in = fin_r;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Pins are asynchronous; only the last stage feeds the routing
  always_comb begin
    sync_nxt[0] = pin_in;
    for (int i = 1; i < SYNC_STAGES; i++) begin
      sync_nxt[i] = sync_r[i-1];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_r[i] <= '0;
      end
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign pin_s = sync_r[SYNC_STAGES-1];

  // ----------------------------------------------------------------------
  // Wishbone slave and selector bank
  // ----------------------------------------------------------------------
  // Unmapped addresses are still acked so the master never hangs
  always_comb begin
    req = wb_req.cyc & wb_req.stb;
    wr_go = req & wb_req.we & ack_r & wb_req.sel[0];
    ack_nxt = req & ~ack_r;
    rd_val = '0;
    sel_nxt = sel_r;
    for (int i = 0; i < FPL_NUM_SEL; i++) begin
      if (wb_req.adr == FPL_ADR_TABLE[i]) begin
        rd_val = {{(FPL_DATA_W-FPL_SEL_W){1'b0}}, sel_r[i]}; // see RQ16
        if (wr_go) begin
          sel_nxt[i] = wb_req.dat[FPL_FIELD_MSB:FPL_FIELD_LSB]; // see RQ16
        end
      end
    end
    if (wb_req.adr == FPL_ADR_INPUT_STATUS) begin
      rd_val = {{(FPL_DATA_W-$bits(fpl_func_in_t)){1'b0}}, fin_r};
    end
    dat_nxt = (req & ~ack_r) ? rd_val : '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      for (int i = 0; i < FPL_NUM_SEL; i++) begin
        sel_r[i] <= FPL_SEL_RESET; // see RQ1 see RQ3 see RQ5 see RQ7 see RQ9 see RQ11 see RQ13
      end
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      sel_r <= sel_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------------
  // Driven from the next selector so a write acts at its own edge
  always_comb begin
    pout_nxt = '0;
    poe_nxt = '0;
    fin_nxt = '0;
    unique case (sel_nxt[FPL_IX_SPI0_CLOCK]) // see RQ2 see RQ17
      FPL_CODE_0: begin
        pout_nxt[FPL_PIN_PORT0_BIT10] = spi0_serial_clock.o;
        poe_nxt[FPL_PIN_PORT0_BIT10] = spi0_serial_clock.oe;
        fin_nxt.spi0_serial_clock = pin_s[FPL_PIN_PORT0_BIT10];
      end
      FPL_CODE_1: begin
        pout_nxt[FPL_PIN_PORT2_BIT11] = spi0_serial_clock.o;
        poe_nxt[FPL_PIN_PORT2_BIT11] = spi0_serial_clock.oe;
        fin_nxt.spi0_serial_clock = pin_s[FPL_PIN_PORT2_BIT11];
      end
      FPL_CODE_2: begin
        pout_nxt[FPL_PIN_PORT0_BIT6] = spi0_serial_clock.o;
        poe_nxt[FPL_PIN_PORT0_BIT6] = spi0_serial_clock.oe;
        fin_nxt.spi0_serial_clock = pin_s[FPL_PIN_PORT0_BIT6];
      end
      default: ; // Reserved code leaves the function unrouted, see RQ15
    endcase
    unique case (sel_nxt[FPL_IX_SPI1_SELECT]) // see RQ10
      FPL_CODE_0: begin
        pout_nxt[FPL_PIN_PORT2_BIT0] = spi1_slave_select.o;
        poe_nxt[FPL_PIN_PORT2_BIT0] = spi1_slave_select.oe;
        fin_nxt.spi1_slave_select = pin_s[FPL_PIN_PORT2_BIT0];
      end
      FPL_CODE_1: begin
        pout_nxt[FPL_PIN_PORT2_BIT4] = spi1_slave_select.o;
        poe_nxt[FPL_PIN_PORT2_BIT4] = spi1_slave_select.oe;
        fin_nxt.spi1_slave_select = pin_s[FPL_PIN_PORT2_BIT4];
      end
      default: ;
    endcase
    unique case (sel_nxt[FPL_IX_SPI1_CLOCK]) // see RQ14
      FPL_CODE_0: begin
        pout_nxt[FPL_PIN_PORT2_BIT1] = spi1_serial_clock.o;
        poe_nxt[FPL_PIN_PORT2_BIT1] = spi1_serial_clock.oe;
        fin_nxt.spi1_serial_clock = pin_s[FPL_PIN_PORT2_BIT1];
      end
      FPL_CODE_1: begin
        pout_nxt[FPL_PIN_PORT3_BIT2] = spi1_serial_clock.o;
        poe_nxt[FPL_PIN_PORT3_BIT2] = spi1_serial_clock.oe;
        fin_nxt.spi1_serial_clock = pin_s[FPL_PIN_PORT3_BIT2];
      end
      default: ;
    endcase
    // Input-only functions may share a pin; each just listens
    unique case (sel_nxt[FPL_IX_SET_READY]) // see RQ4
      FPL_CODE_0: fin_nxt.uart_set_ready = pin_s[FPL_PIN_PORT2_BIT1];
      FPL_CODE_1: fin_nxt.uart_set_ready = pin_s[FPL_PIN_PORT3_BIT1];
      default: ;
    endcase
    unique case (sel_nxt[FPL_IX_CARRIER_DETECT]) // see RQ6
      FPL_CODE_0: fin_nxt.uart_carrier_detect = pin_s[FPL_PIN_PORT2_BIT2];
      FPL_CODE_1: fin_nxt.uart_carrier_detect = pin_s[FPL_PIN_PORT3_BIT2];
      default: ;
    endcase
    unique case (sel_nxt[FPL_IX_BELL_INPUT]) // see RQ8
      FPL_CODE_0: fin_nxt.uart_phone_bell_input = pin_s[FPL_PIN_PORT2_BIT3];
      FPL_CODE_1: fin_nxt.uart_phone_bell_input = pin_s[FPL_PIN_PORT3_BIT3];
      default: ;
    endcase
    unique case (sel_nxt[FPL_IX_TIMER16_CAPTURE]) // see RQ12
      FPL_CODE_0: fin_nxt.timer16_0_capture0_input = pin_s[FPL_PIN_PORT0_BIT2];
      FPL_CODE_1: fin_nxt.timer16_0_capture0_input = pin_s[FPL_PIN_PORT3_BIT3];
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pout_r <= '0;
      poe_r <= '0;
      fin_r <= '0;
    end else begin
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
      fin_r <= fin_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_spi0_clk_reset;
    $past(rst) |-> sel_r[FPL_IX_SPI0_CLOCK] == FPL_SEL_RESET;
  endproperty
  a_spi0_clk_reset: assert property (p_spi0_clk_reset) else $error("spi0 clock sel reset"); // see RQ1

  property p_spi0_clk_route;
    sel_r[FPL_IX_SPI0_CLOCK] == FPL_CODE_1 |-> poe_r[FPL_PIN_PORT2_BIT11] ==
      $past(spi0_serial_clock.oe) && !poe_r[FPL_PIN_PORT0_BIT10] && !poe_r[FPL_PIN_PORT0_BIT6];
  endproperty
  a_spi0_clk_route: assert property (p_spi0_clk_route) else $error("spi0 clock route"); // see RQ2

  property p_ready_reset;
    $past(rst) |-> sel_r[FPL_IX_SET_READY] == FPL_SEL_RESET;
  endproperty
  a_ready_reset: assert property (p_ready_reset) else $error("set ready sel reset"); // see RQ3

  property p_ready_route;
    sel_r[FPL_IX_SET_READY] == FPL_CODE_1 |-> fin_r.uart_set_ready ==
      $past(pin_s[FPL_PIN_PORT3_BIT1]);
  endproperty
  a_ready_route: assert property (p_ready_route) else $error("set ready route"); // see RQ4

  property p_carrier_reset;
    $past(rst) |-> sel_r[FPL_IX_CARRIER_DETECT] == FPL_SEL_RESET;
  endproperty
  a_carrier_reset: assert property (p_carrier_reset) else $error("carrier sel reset"); // see RQ5

  property p_carrier_route;
    sel_r[FPL_IX_CARRIER_DETECT] == FPL_CODE_0 |-> fin_r.uart_carrier_detect ==
      $past(pin_s[FPL_PIN_PORT2_BIT2]);
  endproperty
  a_carrier_route: assert property (p_carrier_route) else $error("carrier route"); // see RQ6

  property p_bell_reset;
    $past(rst) |-> sel_r[FPL_IX_BELL_INPUT] == FPL_SEL_RESET;
  endproperty
  a_bell_reset: assert property (p_bell_reset) else $error("bell sel reset"); // see RQ7

  property p_bell_route;
    sel_r[FPL_IX_BELL_INPUT] == FPL_CODE_1 |-> fin_r.uart_phone_bell_input ==
      $past(pin_s[FPL_PIN_PORT3_BIT3]);
  endproperty
  a_bell_route: assert property (p_bell_route) else $error("bell route"); // see RQ8

  property p_sel1_reset;
    $past(rst) |-> sel_r[FPL_IX_SPI1_SELECT] == FPL_SEL_RESET;
  endproperty
  a_sel1_reset: assert property (p_sel1_reset) else $error("spi1 select sel reset"); // see RQ9

  property p_sel1_route;
    sel_r[FPL_IX_SPI1_SELECT] == FPL_CODE_0 |-> pout_r[FPL_PIN_PORT2_BIT0] ==
      $past(spi1_slave_select.o) && !poe_r[FPL_PIN_PORT2_BIT4];
  endproperty
  a_sel1_route: assert property (p_sel1_route) else $error("spi1 select route"); // see RQ10

  property p_cap_reset;
    $past(rst) |-> sel_r[FPL_IX_TIMER16_CAPTURE] == FPL_SEL_RESET;
  endproperty
  a_cap_reset: assert property (p_cap_reset) else $error("capture sel reset"); // see RQ11

  property p_cap_route;
    sel_r[FPL_IX_TIMER16_CAPTURE] == FPL_CODE_0 |-> fin_r.timer16_0_capture0_input ==
      $past(pin_s[FPL_PIN_PORT0_BIT2]);
  endproperty
  a_cap_route: assert property (p_cap_route) else $error("capture route"); // see RQ12

  property p_clk1_reset;
    $past(rst) |-> sel_r[FPL_IX_SPI1_CLOCK] == FPL_SEL_RESET;
  endproperty
  a_clk1_reset: assert property (p_clk1_reset) else $error("spi1 clock sel reset"); // see RQ13

  property p_clk1_route;
    sel_r[FPL_IX_SPI1_CLOCK] == FPL_CODE_1 |-> poe_r[FPL_PIN_PORT3_BIT2] ==
      $past(spi1_serial_clock.oe) && !poe_r[FPL_PIN_PORT2_BIT1];
  endproperty
  a_clk1_route: assert property (p_clk1_route) else $error("spi1 clock route"); // see RQ14

  property p_upper_zero;
    ack_r && wb_req.adr == FPL_ADR_TABLE[FPL_IX_SPI0_CLOCK] |-> wb_dat_o[31:2] == 30'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // see RQ16

  sequence s_wr_spi0_code2;
    wr_go && wb_req.adr == FPL_ADR_TABLE[FPL_IX_SPI0_CLOCK] && wb_req.dat[1:0] == FPL_CODE_2;
  endsequence
  property p_write_effect;
    s_wr_spi0_code2 |=> sel_r[FPL_IX_SPI0_CLOCK] == FPL_CODE_2 &&
      poe_r[FPL_PIN_PORT0_BIT6] == $past(spi0_serial_clock.oe);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("write not effective"); // see RQ17

  property p_one_pin;
    $onehot0({poe_r[FPL_PIN_PORT0_BIT10], poe_r[FPL_PIN_PORT2_BIT11], poe_r[FPL_PIN_PORT0_BIT6]});
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("spi0 clock on two pins"); // see RQ17

endmodule : fpl_function_pin_location_select
`default_nettype wire

// file: tb_fpl_function_pin_location_select.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_fpl_function_pin_location_select;
  import fpl_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct {int ix; logic [1:0] code; int pin; int fbit; int drv;} fpl_row_t;
  localparam int LIMIT = 5000;
  logic clk_sys, rst, wb_ack_o;
  fpl_wb_req_t wb_req;
  logic [31:0] wb_dat_o, rd;
  logic [FPL_NUM_PIN-1:0] pin_in, pin_out, pin_oe;
  fpl_drive_t spi0_drv, spi1_drv, ssel_drv;
  fpl_func_in_t func_in;
  logic [6:0] fi;
  int n_errors = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  // Index, code, pin, func_in bit, driving function (0 none, 1 spi0, 2 spi1 clk, 3 select)
  fpl_row_t rows [15] = '{
    '{1, 2'h0, 0, 6, 1}, '{1, 2'h1, 1, 6, 1}, '{1, 2'h2, 2, 6, 1},
    '{2, 2'h0, 3, 3, 0}, '{2, 2'h1, 4, 3, 0}, '{3, 2'h0, 5, 2, 0}, '{3, 2'h1, 6, 2, 0},
    '{4, 2'h0, 7, 1, 0}, '{4, 2'h1, 8, 1, 0}, '{0, 2'h0, 9, 4, 3}, '{0, 2'h1, 10, 4, 3},
    '{5, 2'h0, 11, 0, 0}, '{5, 2'h1, 8, 0, 0}, '{6, 2'h0, 3, 5, 2}, '{6, 2'h1, 6, 5, 2}};

  assign fi = func_in;

  fpl_function_pin_location_select #(
    .SYNC_STAGES(2)
  ) fpl_function_pin_location_select_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_req(wb_req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .spi0_serial_clock(spi0_drv),
    .spi1_serial_clock(spi1_drv),
    .spi1_slave_select(ssel_drv),
    .func_in(func_in)
  );

  always #20 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Bus tasks and closing report
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Holds the request until ack is sampled, so slow answers are tolerated
  task automatic wb_cycle(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_req <= '0;
    `CHK("ack", 1'b1, wb_ack_o)
  endtask : wb_cycle

  task automatic wb_wr(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] q;
    wb_cycle(1'b1, adr, dat, sel, q);
  endtask : wb_wr

  task automatic wb_rd(input logic [31:0] adr, output logic [31:0] q);
    wb_cycle(1'b0, adr, 32'h0, 4'hf, q);
  endtask : wb_rd

  task automatic check_reset_values();
    for (int i = 0; i < FPL_NUM_SEL; i++) begin
      wb_rd(FPL_ADR_TABLE[i], rd);
      `CHK("reset selector", 32'h0, rd)
    end
    $display("test reset values done");
  endtask : check_reset_values

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    wb_req = '0;
    pin_in = '0;
    spi0_drv = '0;
    spi1_drv = '0;
    ssel_drv = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    check_reset_values();
    for (int r = 0; r < 15; r++) begin
      @(posedge clk_sys);
      spi0_drv <= '{o: 1'b1, oe: (rows[r].drv == 1)};
      spi1_drv <= '{o: 1'b1, oe: (rows[r].drv == 2)};
      ssel_drv <= '{o: 1'b1, oe: (rows[r].drv == 3)};
      // Upper ones must be dropped by the register
      wb_wr(FPL_ADR_TABLE[rows[r].ix], 32'hffff_fffc | 32'(rows[r].code), 4'hf);
      #1;
      if (rows[r].drv != 0) begin
        `CHK("pin_oe", 12'h1 << rows[r].pin, pin_oe)
        `CHK("pin_out", 1'b1, pin_out[rows[r].pin])
      end
      wb_rd(FPL_ADR_TABLE[rows[r].ix], rd);
      `CHK("selector", {30'h0, rows[r].code}, rd)
      @(posedge clk_sys);
      pin_in <= 12'h1 << rows[r].pin;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("func_in high", 1'b1, fi[rows[r].fbit])
      @(posedge clk_sys);
      pin_in <= ~(12'h1 << rows[r].pin);
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("func_in low", 1'b0, fi[rows[r].fbit])
    end
    $display("test routing table done");
    // Reserved code leaves the clock unrouted even with the driver enabled
    @(posedge clk_sys);
    spi0_drv <= '{o: 1'b1, oe: 1'b1};
    spi1_drv <= '0;
    ssel_drv <= '0;
    pin_in <= '1;
    wb_wr(FPL_ADR_TABLE[FPL_IX_SPI0_CLOCK], 32'h3, 4'hf);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("reserved pin_oe", 12'h0, pin_oe)
    `CHK("reserved func_in", 1'b0, fi[6])
    wb_rd(FPL_ADR_TABLE[FPL_IX_TIMER16_CAPTURE], rd);
    `CHK("capture selector", 32'h1, rd)
    // All pins high; every function but the spi0 clock sits on code 1
    wb_rd(FPL_ADR_INPUT_STATUS, rd);
    `CHK("input status", 32'h0000_003f, rd)
    $display("test reserved code done");
    // Byte lane zero disabled: the write must not land
    wb_wr(FPL_ADR_TABLE[FPL_IX_SET_READY], 32'h0, 4'he);
    wb_rd(FPL_ADR_TABLE[FPL_IX_SET_READY], rd);
    `CHK("lane off", 32'h1, rd)
    wb_wr(32'h4004_4000, 32'hffff_ffff, 4'hf);
    wb_rd(32'h4004_4000, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test refused writes done");
    // Reset in mid-run returns every selector to its default
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK("pin_oe after reset", 12'h0, pin_oe)
    // Spi0 driver still enabled, so the default code puts it on port0 bit10
    @(posedge clk_sys);
    #1;
    `CHK("pin_oe default route", 12'h1, pin_oe)
    check_reset_values();
    print_verdict();
  end
endmodule : tb_fpl_function_pin_location_select
`default_nettype wire
